// ### scl_timing_map.svh
`ifndef SCL_TIMING_MAP_SVH
`define SCL_TIMING_MAP_SVH
// Clock rate in MHz
`define CLK_MHZ 50
// Mixed-bus high-time ceiling in ns, stays under the 50 ns legacy filter
`define MIXED_HIGH_MAX_NS 45
// General minimum SCL high time in ns
`define HIGH_MIN_NS 24
// Stall ceilings
`define STALL_SHORT_US 100
`define STALL_LONG_MS 15
// Cycle counts; longest times round down
`define MIXED_HIGH_MAX_CYC ((`MIXED_HIGH_MAX_NS * `CLK_MHZ) / 1000)
`define HIGH_MIN_CYC (((`HIGH_MIN_NS * `CLK_MHZ) + 999) / 1000)
`define STALL_SHORT_CYC (`STALL_SHORT_US * `CLK_MHZ)
`define STALL_LONG_CYC (`STALL_LONG_MS * 1000 * `CLK_MHZ)
// Fast-mode plus low/high floor in cycles (500 ns low, 260 ns high)
`define LEGACY_LOW_CYC 25
`define LEGACY_HIGH_CYC 13
`endif

// ### scl_timing_pkg.sv
package scl_timing_pkg;
  typedef enum logic [1:0] {
    BUS_PURE = 2'b00,
    BUS_MIXED_FAST = 2'b01,
    BUS_MIXED_SLOW = 2'b10
  } bus_cfg_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b11,
    ST_STALL = 2'b10
  } scl_state_t;
  typedef enum logic [1:0] {
    STALL_ACK = 2'b00,
    STALL_PARITY = 2'b01,
    STALL_TBIT = 2'b10,
    STALL_DAA = 2'b11
  } stall_kind_t;
endpackage

// ### sdr_scl_duty_and_stall_control.sv
`timescale 1ns/10ps
`include "scl_timing_map.svh"
// Behaviour
// - Bus is pure, mixed fast or mixed slow
// - Mixed slow bus uses legacy rates unless all legacy parts are the fast index class
// - Pure bus uses programmed timing, floored at the general minimum
// - Mixed fast: legacy slow, I3C short high
// - Mixed fast I3C high under ceiling
// - Rate lowered by stretching low time
// - Short high stays above general minimum
// - Stall only low, four bit positions
// - No stall beyond 15 ms
// - 100 us short stalls, 15 ms DAA
// - Stall only while requested, shortest possible
// - After stall, normal high timing resumes
// - Ack stall serves data, IBI, CCC readiness
// - Parity bit stall on write underrun
// - Transition bit stall on read overflow
// - First assigned-address bit stall allowed
module sdr_scl_duty_and_stall_control #(
  parameter int unsigned STALL_SHORT_CYCLES = `STALL_SHORT_CYC, // Short stall limit
  parameter int unsigned STALL_LONG_CYCLES = `STALL_LONG_CYC // DAA stall limit
) (
  input wire logic i_clk, // System clock, 50 MHz
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic [1:0] i_bus_cfg, // Bus configuration
  input wire logic [7:0] i_high_cycles, // Programmed SCL high count
  input wire logic [7:0] i_low_cycles, // Programmed SCL low count
  input wire logic i_legacy_msg, // Current message is to a legacy target
  input wire logic i_all_index1, // All legacy parts are the fast index class
  input wire logic i_run, // Keep clocking bits
  input wire logic i_stall_req, // Request to hold SCL low in this bit
  input wire logic [1:0] i_stall_kind, // Which bit position is current
  input wire logic i_stall_point, // Current bit is one of the stall points
  input wire logic i_scl_in, // Sensed SCL level from the pin
  output logic o_scl_oe, // High while SCL is pulled low
  output logic o_scl_out, // SCL drive value, always low
  output logic o_bit_tick, // One-cycle pulse on each SCL rise
  output logic o_stalling, // SCL held low by a stall
  output logic o_stall_timeout // Pulse when a stall was cut at its limit
);
  typedef struct packed {
    scl_timing_pkg::scl_state_t state; // Bit phase
    logic [23:0] cnt; // Cycles spent in the phase
    logic [7:0] len; // Length of the running phase
    logic [23:0] stall_cap; // Ceiling frozen when the stall began
    logic [1:0] sync; // Two-stage sampler of the sensed line
    logic short_high; // Running high pulse is a short one
    logic tick; // Release pulse
    logic timeout; // Stall cut pulse
  } state_t;

  // Registered state and its next value
  state_t cur;
  state_t next_cur;

  // Phase lengths for the current bus setup
  logic [7:0] eff_high;
  logic [7:0] eff_low;
  logic short_now;
  logic legacy_now;

  // Ceiling of a stall that would start now
  logic [23:0] stall_lim;

  // Phase-end decisions
  logic low_done;
  logic stall_take;
  logic stall_done;
  logic high_counting;
  logic high_done;

  // Timing summary, in clock cycles:
  // - low phase: exactly the clamped low count, SCL held low
  // - stall: the low phase goes on until the request drops or the ceiling nears
  // - short high: exactly the clamped high count, started at release
  // - other highs: the clamped high count of sensed-high cycles, so the rise time
  //   and the two-stage sampler only lengthen the pulse
  // A short high cannot wait for the sampler: two cycles of lag on top of the
  // two-cycle minimum would break the mixed-bus ceiling. Long, heavily loaded lines are a known
  // limit of short highs: the data line may not settle within them.

  // Clamp a count between a floor and a ceiling
  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Short high pulses are only for I3C traffic on a mixed fast bus
  function automatic logic is_short_high(input logic [1:0] cfg, input logic legacy);
    case (scl_timing_pkg::bus_cfg_t'(cfg))
      scl_timing_pkg::BUS_MIXED_FAST: begin
        is_short_high = !legacy;
      end
      default: begin
        is_short_high = 1'b0;
      end
    endcase
  endfunction

  // Legacy floors apply wherever a legacy part must see every pulse
  function automatic logic is_legacy_timing(input logic [1:0] cfg, input logic legacy,
                                            input logic idx1);
    case (scl_timing_pkg::bus_cfg_t'(cfg))
      scl_timing_pkg::BUS_PURE: begin
        is_legacy_timing = 1'b0;
      end
      scl_timing_pkg::BUS_MIXED_FAST: begin
        is_legacy_timing = legacy;
      end
      default: begin
        // Parts without a true filter see every pulse; only the fast class may skip it
        is_legacy_timing = !idx1;
      end
    endcase
  endfunction

  // Compare a running count, plus a margin, against a phase length
  function automatic logic reached(input logic [23:0] count, input logic [23:0] margin,
                                   input logic [23:0] limit);
    reached = (count + margin) >= limit;
  endfunction

  // Count up without wrapping; a wrapped count could hold a phase past its length
  function automatic logic [23:0] bump(input logic [23:0] count);
    if (count == 24'hff_ffff) begin
      bump = count;
    end else begin
      bump = count + 24'h00_0001;
    end
  endfunction

  // Ceiling for a stall at the given bit position
  function automatic logic [23:0] ceiling_for(input logic [1:0] kind);
    case (scl_timing_pkg::stall_kind_t'(kind))
      scl_timing_pkg::STALL_DAA: begin
        ceiling_for = 24'(STALL_LONG_CYCLES);
      end
      default: begin
        ceiling_for = 24'(STALL_SHORT_CYCLES);
      end
    endcase
  endfunction

  // Bus setups: pure, mixed fast, mixed slow; code 3 is read as mixed slow
  always_comb begin
    short_now = is_short_high(i_bus_cfg, i_legacy_msg);
    legacy_now = is_legacy_timing(i_bus_cfg, i_legacy_msg, i_all_index1);
  end

  // Pick high and low lengths; the requested counts are clamped, never refused
  always_comb begin
    if (short_now) begin
      // Short high hides I3C from the spike filter; rate set by low only
      eff_high = clamp(i_high_cycles, 8'(`HIGH_MIN_CYC),
                       8'(`MIXED_HIGH_MAX_CYC));
      eff_low = clamp(i_low_cycles, 8'(`HIGH_MIN_CYC), 8'hff);
    end else if (legacy_now) begin
      // Legacy parts need full Fm+ pulses on both halves
      eff_high = clamp(i_high_cycles, 8'(`LEGACY_HIGH_CYC), 8'hff);
      eff_low = clamp(i_low_cycles, 8'(`LEGACY_LOW_CYC), 8'hff);
    end else begin
      // Pure bus or fast-class legacy parts: programmed timing, floored at the general minimum
      eff_high = clamp(i_high_cycles, 8'(`HIGH_MIN_CYC), 8'hff);
      eff_low = clamp(i_low_cycles, 8'(`HIGH_MIN_CYC), 8'hff);
    end
  end

  // Stall ceilings, in clock cycles, by bit position:
  // - acknowledge, write parity and read transition bits: short ceiling
  // - first bit of an assigned dynamic address: long ceiling, also the absolute cap
  // The ceiling is frozen when the stall begins, so a position change while
  // stalled cannot lengthen it.
  always_comb begin
    stall_lim = ceiling_for(i_stall_kind);
  end

  // Phase-end decisions, apart from the state update
  always_comb begin
    low_done = reached(cur.cnt, 24'h00_0001, {16'h0000, cur.len});
    // Stall only at an allowed point, only while asked for
    stall_take = i_stall_req && i_stall_point;
    // Counter cuts the stall one cycle short of its ceiling
    stall_done = !i_stall_req || reached(cur.cnt, 24'h00_0002, cur.stall_cap);
    // Slow pulses wait for the sensed rise; short pulses cannot afford the lag
    high_counting = cur.sync[1] || cur.short_high;
    high_done = high_counting && reached(cur.cnt, 24'h00_0001, {16'h0000, cur.len});
  end

  // Phase walk: idle, then low and high in turn while running; low goes to stall
  // when a stall is taken. Gray codes keep each usual step to one bit.
  always_comb begin
    next_cur = cur;
    // Only the second sampler stage is read, so a metastable first stage stays local
    next_cur.sync = {cur.sync[0], i_scl_in};
    next_cur.tick = 1'b0;
    next_cur.timeout = 1'b0;
    case (cur.state)
      scl_timing_pkg::ST_IDLE: begin
        // Line released; wait for the next bit
        next_cur.cnt = 24'h00_0000;
        next_cur.short_high = 1'b0;
        if (i_run) begin
          next_cur.state = scl_timing_pkg::ST_LOW;
          next_cur.len = eff_low;
        end
      end
      scl_timing_pkg::ST_LOW: begin
        next_cur.cnt = bump(cur.cnt);
        if (low_done) begin
          next_cur.cnt = 24'h00_0000;
          if (stall_take) begin
            next_cur.state = scl_timing_pkg::ST_STALL;
            next_cur.stall_cap = stall_lim;
          end else begin
            // Release; the pulse kind is frozen so a setup change cannot stretch it
            next_cur.state = scl_timing_pkg::ST_HIGH;
            next_cur.len = eff_high;
            next_cur.short_high = short_now;
            next_cur.tick = 1'b1;
          end
        end
      end
      scl_timing_pkg::ST_STALL: begin
        // Line still held low against the ceiling frozen at entry
        next_cur.cnt = bump(cur.cnt);
        if (stall_done) begin
          // Released: the next rise follows normal high timing
          next_cur.timeout = i_stall_req;
          next_cur.state = scl_timing_pkg::ST_HIGH;
          next_cur.cnt = 24'h00_0000;
          next_cur.len = eff_high;
          next_cur.short_high = short_now;
          next_cur.tick = 1'b1;
        end
      end
      scl_timing_pkg::ST_HIGH: begin
        // Legacy targets never stretch, so the sensed rise only adds rise time
        if (high_counting) begin
          next_cur.cnt = bump(cur.cnt);
        end
        // Back to low only after the full high time
        if (high_done) begin
          next_cur.cnt = 24'h00_0000;
          next_cur.len = eff_low;
          next_cur.short_high = 1'b0;
          next_cur.state = i_run ? scl_timing_pkg::ST_LOW : scl_timing_pkg::ST_IDLE;
        end
      end
      default: begin
        next_cur.state = scl_timing_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; every field resets to zero, which leaves SCL released
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Output decode from the registered phase only, never from an input
  always_comb begin
    o_scl_oe = 1'b0;
    o_stalling = 1'b0;
    case (cur.state)
      scl_timing_pkg::ST_LOW: begin
        o_scl_oe = 1'b1;
      end
      scl_timing_pkg::ST_STALL: begin
        // A stall is only ever a held low
        o_scl_oe = 1'b1;
        o_stalling = 1'b1;
      end
      default: begin
        // Idle and high phases leave the line to the pull-up
        o_scl_oe = 1'b0;
        o_stalling = 1'b0;
      end
    endcase
  end

  // The line is open drain: the driven value is always low
  assign o_scl_out = 1'b0;
  // Pulses come straight from flip-flops
  assign o_bit_tick = cur.tick;
  assign o_stall_timeout = cur.timeout;
endmodule

// ### scl_target_model.sv
`timescale 1ns/10ps
// Targets never stretch SCL, so only the pull-up and the controller set it
module scl_target_model (
  input wire logic i_scl_oe, // Controller pulls SCL low
  output logic o_scl // Resolved SCL level
);
  assign o_scl = i_scl_oe ? 1'h0 : 1'h1;
endmodule

// ### sdr_scl_duty_and_stall_control_sva.sv
`timescale 1ns/10ps
module scl_ctl_chk #(
  parameter int unsigned STALL_SHORT_CYCLES = 5000, // Short stall limit
  parameter int unsigned STALL_LONG_CYCLES = 750000 // Address stall limit
) (
  input wire logic i_clk, i_sys_rst, i_legacy_msg, i_run, i_stall_req, i_stall_point, // Inputs
  input wire logic [1:0] i_bus_cfg, i_stall_kind, // Mode inputs
  input wire logic o_scl_oe, o_bit_tick, o_stalling, o_stall_timeout // Outputs
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Stall length, and the kind sampled each cycle outside a stall and held through it, so the limit follows the stalled bit
  int unsigned cnt;
  logic [1:0] kind;
  always_ff @(posedge i_clk) begin
    cnt <= o_stalling ? cnt + 1 : 0;
    kind <= o_stalling ? kind : i_stall_kind;
  end
  property p_stall_oe; o_stalling |-> o_scl_oe; endproperty
  a_stall_oe: assert property (p_stall_oe) else $error("stall without low");
  property p_cause; $rose(o_stalling) |-> $past(i_stall_req && i_stall_point); endproperty
  a_cause: assert property (p_cause) else $error("stall not asked");
  property p_release; o_stalling && !i_stall_req |=> !o_stalling; endproperty
  a_release: assert property (p_release) else $error("stall kept");
  property p_short; o_stalling && kind != 2'h3 |-> cnt < STALL_SHORT_CYCLES; endproperty
  a_short: assert property (p_short) else $error("short stall too long");
  property p_long; o_stalling |-> cnt < STALL_LONG_CYCLES; endproperty
  a_long: assert property (p_long) else $error("stall too long");
  property p_tick; o_bit_tick |-> $past(o_scl_oe) ##0 (!o_scl_oe) [*2]; endproperty
  a_tick: assert property (p_tick) else $error("bad release");
  property p_mixed; o_bit_tick && i_bus_cfg == 2'h1 && !i_legacy_msg && i_run
    |-> ##[1:2] o_scl_oe; endproperty
  a_mixed: assert property (p_mixed) else $error("mixed high too long");
  property p_cut; o_stall_timeout |-> o_bit_tick ##1 !o_stall_timeout; endproperty
  a_cut: assert property (p_cut) else $error("bad timeout pulse");
endmodule
bind sdr_scl_duty_and_stall_control scl_ctl_chk #(.STALL_SHORT_CYCLES(STALL_SHORT_CYCLES),
  .STALL_LONG_CYCLES(STALL_LONG_CYCLES)) scl_ctl_chk_i (.i_clk, .i_sys_rst, .i_legacy_msg,
  .i_run, .i_stall_req, .i_stall_point, .i_bus_cfg, .i_stall_kind, .o_scl_oe, .o_bit_tick,
  .o_stalling, .o_stall_timeout);

// ### sdr_scl_duty_and_stall_control_tb_top.sv
`timescale 1ns/10ps
module sdr_scl_duty_and_stall_control_tb_top;
  logic i_clk = 1'h0, i_sys_rst = 1'h1, i_legacy_msg = 1'h0, i_all_index1 = 1'h0, scl;
  logic i_run = 1'h0, i_stall_req = 1'h0, i_stall_point = 1'h0;
  logic o_scl_oe, o_bit_tick, o_stalling, o_stall_timeout;
  logic [1:0] i_bus_cfg = 2'h0, i_stall_kind = 2'h0;
  logic [7:0] i_high_cycles = 8'h0a, i_low_cycles = 8'h1e;
  logic [3:0] tbl [6] = '{4'h0, 4'h2, 4'ha, 4'h3, 4'h5, 4'h1};
  int error_cnt = 0, total_checks = 0, lowcnt = 0, lo, e;
  int exp_q[$];
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  // Short stall limits keep the cut-off cases brief
  sdr_scl_duty_and_stall_control #(.STALL_SHORT_CYCLES(20), .STALL_LONG_CYCLES(60))
    sdr_scl_duty_and_stall_control_i (.i_clk, .i_sys_rst, .i_bus_cfg, .i_high_cycles,
    .i_low_cycles, .i_legacy_msg, .i_all_index1, .i_run, .i_stall_req, .i_stall_kind,
    .i_stall_point, .i_scl_in(scl), .o_scl_oe, .o_scl_out(), .o_bit_tick, .o_stalling,
    .o_stall_timeout);
  scl_target_model scl_target_model_i (.i_scl_oe(o_scl_oe), .o_scl(scl));
  task automatic check(string what, logic [15:0] seen, logic [15:0] expv);
    total_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, expv, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for n SCL releases
  task automatic ticks(int n);
    for (int k = 0; k < 4000 && n > 0; k++) begin
      @(posedge i_clk);
      if (o_bit_tick === 1'h1) n--;
    end
    if (n > 0) begin
      check("wait", 16'h0001, 16'h0000);
      summarize();
    end
  endtask
  // Each release pops the oldest note: low length times two plus timeout flag
  always @(posedge i_clk) begin
    if (o_scl_oe === 1'h1) lowcnt++;
    if (o_bit_tick === 1'h1) begin
      check("note", 16'(exp_q.size() > 0), 16'h0001);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
      if (e >= 0) check("low", 16'(lowcnt), 16'(e >>> 1));
      check("timeout", 16'(o_stall_timeout), 16'(e & 1));
      lowcnt = 0;
    end
  end
  // Every bus setup, then each stall position, an early drop and a refused stall
  initial begin
    void'($urandom(65));
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_clk);
    i_run <= 1'h1;
    foreach (tbl[t]) begin
      lo = $urandom_range(90, 5);
      {i_all_index1, i_legacy_msg, i_bus_cfg} <= tbl[t];
      i_low_cycles <= 8'(lo);
      i_high_cycles <= 8'($urandom_range(20, 2));
      exp_q.push_back(-2);
      if ((tbl[t][1] && !tbl[t][3] || tbl[t][2]) && lo < 25) lo = 25;
      repeat (2) exp_q.push_back(lo * 2);
      ticks(3);
    end
    for (int k = 0; k < 4; k++) begin
      i_stall_req <= 1'h1;
      i_stall_point <= 1'h1;
      i_stall_kind <= 2'(k);
      exp_q.push_back((lo + ((k == 3) ? 59 : 19)) * 2 + 1);
      ticks(1);
    end
    exp_q.push_back(-2);
    for (int k = 0; k < 300 && o_stalling !== 1'h1; k++) @(posedge i_clk);
    repeat (30) @(posedge i_clk);
    check("stalling", 16'(o_stalling), 16'h0001);
    i_stall_req <= 1'h0;
    ticks(1);
    i_stall_point <= 1'h0;
    i_stall_req <= 1'h1;
    exp_q.push_back(lo * 2);
    ticks(1);
    repeat (2) @(posedge i_clk);
    check("left", 16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule
